// ===== rtl/ptw_bus_if.sv
`timescale 1ns/10ps
interface ptw_bus_if;
	logic frame_b;
	logic frame_oe;
	logic irdy_b;
	logic irdy_oe;
	logic [63:0] ad;
	logic ad_oe;
	logic [3:0] cbe_b;
	logic cbe_oe;
	logic trdy_b;
	logic devsel_b;
	logic tgt_oe;
	modport master (output frame_b, frame_oe, irdy_b, irdy_oe, ad, ad_oe, cbe_b, cbe_oe,
		input trdy_b, devsel_b, tgt_oe);
	modport target (input frame_b, frame_oe, irdy_b, irdy_oe, ad, ad_oe, cbe_b, cbe_oe,
		output trdy_b, devsel_b, tgt_oe);
endinterface

// ===== rtl/ptw_defs.svh
`ifndef PTW_DEFS_SVH
`define PTW_DEFS_SVH
// ----------------------------------------
// command codes and window defaults
// ----------------------------------------
`define PTW_CMD_MEM_WRITE 4'h7
`define PTW_BAR0_BASE 32'h1000_0000
`define PTW_BAR0_MASK 32'hffff_f000
`define PTW_BAR1_BASE 32'h2000_0000
`define PTW_BAR1_MASK 32'hffff_0000
`define PTW_SPEED_SLOW 1'b1
// data-phase clocks a master waits for a select before giving up
`define PTW_ABORT_WAIT 3'h4
`endif

// ===== rtl/ptw_master.sv
`timescale 1ns/10ps
`include "ptw_defs.svh"
module ptw_master import ptw_pkg::*; #(
	parameter int MAX_BURST = 16
) (
	input wire logic clk_i, // 40 MHz clock
	input wire logic rst_b_i, // async reset, low
	input wire logic ce_i, // clock enable
	input wire logic start_i, // start burst pulse
	input wire logic [31:0] addr_i, // burst address
	input wire logic [4:0] len_i, // dword count, 1..16
	input wire logic [31:0] wdata_i, // next dword to send
	input wire logic [3:0] be_b_i, // byte enables, low active
	output logic wnext_o, // dword accepted, advance
	output logic busy_o, // burst in progress
	ptw_bus_if.master bus // pci side
);
	ptw_mst_state_t st_reg;
	logic [4:0] left_reg;
	logic xfer;
	logic abort;
	logic [2:0] wait_reg;
	// ----------------------------------------
	// burst sequencing
	// ----------------------------------------
	assign xfer = st_reg == MST_DATA && !bus.irdy_b && !bus.trdy_b;
	assign wnext_o = xfer;
	assign busy_o = st_reg != MST_IDLE;
	// no target claimed the burst: give the bus up rather than hang in a data phase
	assign abort = st_reg == MST_DATA && bus.devsel_b && wait_reg == `PTW_ABORT_WAIT;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wait_reg <= 3'h0;
		end else if (ce_i) begin
			if (st_reg != MST_DATA) begin
				wait_reg <= 3'h0;
			end else if (bus.devsel_b && !abort) begin
				wait_reg <= wait_reg + 3'h1;
			end
		end
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg <= MST_IDLE;
			left_reg <= 5'h00;
		end else if (ce_i) begin
			unique case (st_reg)
				MST_IDLE: if (start_i) begin
					st_reg <= MST_ADDR;
					left_reg <= (len_i == 5'h00) ? 5'h01 : len_i;
				end
				MST_ADDR: st_reg <= MST_DATA;
				MST_DATA: if (xfer) begin
					left_reg <= left_reg - 5'h01;
					if (left_reg == 5'h01) st_reg <= MST_TURN;
				end else if (abort) begin
					left_reg <= 5'h00;
					st_reg <= MST_TURN;
				end
				MST_TURN: st_reg <= MST_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// bus drive
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus.frame_b <= 1'b1;
			bus.frame_oe <= 1'b0;
			bus.irdy_b <= 1'b1;
			bus.irdy_oe <= 1'b0;
			bus.ad <= 64'h0;
			bus.ad_oe <= 1'b0;
			bus.cbe_b <= 4'hf;
			bus.cbe_oe <= 1'b0;
		end else if (ce_i) begin
			// R1 address phase
			if (st_reg == MST_IDLE && start_i) begin
				bus.frame_b <= 1'b0;
				bus.frame_oe <= 1'b1;
				bus.ad <= {32'h0, addr_i};
				bus.ad_oe <= 1'b1;
				bus.cbe_b <= `PTW_CMD_MEM_WRITE;
				bus.cbe_oe <= 1'b1;
			// R2 first data offered
			end else if (st_reg == MST_ADDR) begin
				bus.irdy_b <= 1'b0;
				bus.irdy_oe <= 1'b1;
				bus.ad <= {32'h0, wdata_i};
				bus.cbe_b <= be_b_i;
				bus.frame_b <= (left_reg == 5'h01);
			end else if (xfer) begin
				if (left_reg == 5'h01) begin
					// R13 release after last phase
					bus.frame_oe <= 1'b0;
					bus.frame_b <= 1'b1;
					bus.ad_oe <= 1'b0;
					bus.cbe_oe <= 1'b0;
					bus.irdy_b <= 1'b1;
				end else begin
					// R9 next dword
					bus.ad <= {32'h0, wdata_i};
					bus.cbe_b <= be_b_i;
					// R12 final phase marked
					bus.frame_b <= (left_reg == 5'h02);
				end
			end else if (abort) begin
				bus.frame_oe <= 1'b0;
				bus.frame_b <= 1'b1;
				bus.ad_oe <= 1'b0;
				bus.cbe_oe <= 1'b0;
				bus.irdy_b <= 1'b1;
			end else if (st_reg == MST_TURN) begin
				bus.irdy_oe <= 1'b0;
			end
		end
	end
endmodule

// ===== rtl/ptw_pkg.sv
package ptw_pkg;
	typedef enum logic [4:0] {
		TGT_IDLE = 5'b00001,
		TGT_DECODE = 5'b00010,
		TGT_HIT = 5'b00100,
		TGT_DATA = 5'b01000,
		TGT_TURN = 5'b10000
	} ptw_tgt_state_t;
	typedef enum logic [3:0] {
		MST_IDLE = 4'b0001,
		MST_ADDR = 4'b0010,
		MST_DATA = 4'b0100,
		MST_TURN = 4'b1000
	} ptw_mst_state_t;
endpackage

// ===== rtl/ptw_target.sv
`timescale 1ns/10ps
`include "ptw_defs.svh"
// Contract
// R1 - master drives frame, address, command first
// R2 - master drives enables, irdy, first dword
// R3 - clock two: decode, present local address
// R4 - clock three: window hit to back-end
// R5 - slow select: devsel after window hit
// R6 - back-end ready means data two later
// R7 - trdy follows ready of prior cycle
// R8 - hold trdy, present prior dword locally
// R9 - master continues after both ready
// R10 - strobe when irdy and ready prior
// R11 - back-end captures only on strobe
// R12 - master lifts frame on last dword
// R13 - master releases bus after last phase
// R14 - drop devsel, trdy after final phase
// R15 - idle: clear hit, strobe, release pins
// R16 - 64-bit bus ignores upper half
// R17 - local handshakes asserted at zero
module ptw_target import ptw_pkg::*; #(
	parameter int NUM_WIN = 2,
	parameter int BUS_WIDTH = 64
) (
	input wire logic clk_i, // 40 MHz clock
	input wire logic rst_b_i, // async reset, low
	input wire logic ce_i, // clock enable
	input wire logic select_response_speed_i, // 1 = slow devsel
	input wire logic backend_ready_low_i, // back-end ready, low
	output logic [31:0] local_target_address_out_o, // latched address
	output logic [NUM_WIN-1:0] window_hit_o, // window chip selects
	output logic [31:0] local_data_out_o, // write dword to back-end
	output logic local_transfer_strobe_low_o, // word taken, low
	ptw_bus_if.target bus // pci side
);
	ptw_tgt_state_t st_reg;
	logic [31:0] ad_lo;
	logic rdy_prev_reg;
	logic addr_phase;
	logic xfer;
	logic done;
	logic sel_now;
	logic is_slow;
	logic [NUM_WIN*32-1:0] bases;
	logic [NUM_WIN*32-1:0] masks;
	logic [NUM_WIN-1:0] hit_next;
	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// R16 upper half ignored
	assign ad_lo = bus.ad[31:0];
	// irdy high marks a fresh address phase; a master stalled in a data
	// phase keeps frame low, and its byte enables must not pass for a command
	assign addr_phase = !bus.frame_b && bus.frame_oe && bus.irdy_b;
	assign xfer = st_reg == TGT_DATA && !bus.trdy_b && !bus.irdy_b;
	// final phase completes this cycle
	assign done = xfer && bus.frame_b;
	assign is_slow = select_response_speed_i == `PTW_SPEED_SLOW;
	// R5 slow speed waits one clock after the hit, fast claims with it
	assign sel_now = (st_reg == TGT_HIT && is_slow) ||
		(st_reg == TGT_DECODE && (|hit_next) && !is_slow);
	// ----------------------------------------
	// window decode
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_WIN; g++) begin : g_cfg
			assign bases[g*32 +: 32] = (g == 0) ? `PTW_BAR0_BASE : `PTW_BAR1_BASE;
			assign masks[g*32 +: 32] = (g == 0) ? `PTW_BAR0_MASK : `PTW_BAR1_MASK;
		end
	endgenerate
	ptw_win_dec #(.NUM_WIN(NUM_WIN)) u_dec (
		.addr_i(local_target_address_out_o),
		.base_i(bases),
		.mask_i(masks),
		.hit_o(hit_next)
	);
	// ----------------------------------------
	// state
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg <= TGT_IDLE;
		end else if (ce_i) begin
			unique case (st_reg)
				TGT_IDLE: if (addr_phase && bus.cbe_b == `PTW_CMD_MEM_WRITE) begin
					st_reg <= TGT_DECODE;
				end
				TGT_DECODE: st_reg <= (|hit_next) ? TGT_HIT : TGT_IDLE;
				TGT_HIT: st_reg <= TGT_DATA;
				TGT_DATA: if (done) begin
					st_reg <= TGT_TURN;
				end
				TGT_TURN: st_reg <= TGT_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// local address
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			local_target_address_out_o <= 32'h0;
		end else if (ce_i) begin
			// R3 present address
			if (st_reg == TGT_IDLE && addr_phase) begin
				local_target_address_out_o <= ad_lo;
			end
		end
	end
	// ----------------------------------------
	// window hit
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			window_hit_o <= '0;
		end else if (ce_i) begin
			// R4 window hit out
			if (st_reg == TGT_DECODE) begin
				window_hit_o <= hit_next;
			// R15 clear hit at idle
			end else if (st_reg == TGT_TURN) begin
				window_hit_o <= '0;
			end
		end
	end
	// ----------------------------------------
	// back-end ready
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdy_prev_reg <= 1'b0;
		end else if (ce_i) begin
			// R17 ready asserted at zero
			rdy_prev_reg <= !backend_ready_low_i && st_reg != TGT_IDLE;
		end
	end
	// ----------------------------------------
	// local data
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			local_data_out_o <= 32'h0;
		end else if (ce_i) begin
			// R8 accepted dword out
			if (xfer) begin
				local_data_out_o <= ad_lo;
			end
		end
	end
	// ----------------------------------------
	// transfer strobe
	// ----------------------------------------
	// one low clock per word, aligned with the data register it qualifies
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			local_transfer_strobe_low_o <= 1'b1;
		end else if (ce_i) begin
			// R10 strobe on irdy and ready
			local_transfer_strobe_low_o <= !(xfer && rdy_prev_reg);
		end
	end
	// ----------------------------------------
	// device select
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus.devsel_b <= 1'b1;
		end else if (ce_i) begin
			// R5 select timing
			if (sel_now) begin
				bus.devsel_b <= 1'b0;
			// R14 drop after final phase
			end else if (done) begin
				bus.devsel_b <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// pin enable
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus.tgt_oe <= 1'b0;
		end else if (ce_i) begin
			if (sel_now) begin
				bus.tgt_oe <= 1'b1;
			// R15 release pins
			end else if (st_reg == TGT_TURN) begin
				bus.tgt_oe <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// target ready
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus.trdy_b <= 1'b1;
		end else if (ce_i) begin
			// R14 trdy dropped after final phase
			if (done || st_reg == TGT_TURN || st_reg == TGT_IDLE) begin
				bus.trdy_b <= 1'b1;
			// R7 trdy tracks prior ready
			end else if (st_reg == TGT_HIT || st_reg == TGT_DATA) begin
				bus.trdy_b <= backend_ready_low_i;
			end
		end
	end
endmodule

// ===== rtl/ptw_win_dec.sv
`timescale 1ns/10ps
`include "ptw_defs.svh"
module ptw_win_dec import ptw_pkg::*; #(
	parameter int NUM_WIN = 2
) (
	input wire logic [31:0] addr_i, // latched bus address
	input wire logic [NUM_WIN*32-1:0] base_i, // window bases
	input wire logic [NUM_WIN*32-1:0] mask_i, // window masks
	output logic [NUM_WIN-1:0] hit_o // per window match
);
	genvar g;
	generate
		for (g = 0; g < NUM_WIN; g++) begin : g_win
			assign hit_o[g] = ((addr_i & mask_i[g*32 +: 32]) ==
				(base_i[g*32 +: 32] & mask_i[g*32 +: 32]));
		end
	endgenerate
endmodule

// ===== tb/ptw_chk_sva.sv
`timescale 1ns/10ps
`include "ptw_defs.svh"
module ptw_chk_sva #(
	parameter int NUM_WIN = 2
) (
	input wire logic clk_i, // clock
	input wire logic rst_b_i, // reset, low
	input wire logic frame_b, // frame, low
	input wire logic irdy_b, // initiator ready, low
	input wire logic trdy_b, // target ready, low
	input wire logic devsel_b, // select, low
	input wire logic tgt_oe, // target drives pins
	input wire logic select_response_speed_i, // 1 = slow select
	input wire logic [63:0] ad, // address and data
	input wire logic [3:0] cbe_b, // command, enables
	input wire logic backend_ready_low_i, // back-end ready, low
	input wire logic [NUM_WIN-1:0] window_hit_o, // chip selects
	input wire logic [31:0] local_target_address_out_o, // local address
	input wire logic [31:0] local_data_out_o, // local data
	input wire logic local_transfer_strobe_low_o // transfer strobe, low
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	AST_ADDR_OUT: assert property ($fell(frame_b) && cbe_b == `PTW_CMD_MEM_WRITE
		|=> local_target_address_out_o == $past(ad[31:0])) else $error("local address wrong");
	AST_HIT_THIRD: assert property ($fell(frame_b) && cbe_b == `PTW_CMD_MEM_WRITE &&
		(ad[31:0] & `PTW_BAR0_MASK) == `PTW_BAR0_BASE |=> ##1 window_hit_o[0])
		else $error("window hit late");
	AST_DEVSEL_SLOW: assert property ($rose(|window_hit_o) |=> !devsel_b)
		else $error("select not one clock after hit");
	AST_DEVSEL_WAIT: assert property ($rose(|window_hit_o) &&
		select_response_speed_i == `PTW_SPEED_SLOW |-> devsel_b)
		else $error("slow select came with the hit");
	AST_DEVSEL_FAST: assert property ($rose(|window_hit_o) &&
		select_response_speed_i != `PTW_SPEED_SLOW |-> !devsel_b)
		else $error("fast select missing at the hit");
	AST_TRDY_FOLLOWS: assert property (!backend_ready_low_i && !devsel_b && !frame_b
		|=> !trdy_b) else $error("target ready missing");
	AST_DATA_OUT: assert property (!irdy_b && !trdy_b && !backend_ready_low_i
		|=> local_data_out_o == $past(ad[31:0])) else $error("local data wrong");
	AST_STROBE: assert property (!irdy_b && !trdy_b && !backend_ready_low_i
		|=> !local_transfer_strobe_low_o) else $error("strobe missing");
	AST_END: assert property (!irdy_b && !trdy_b && frame_b |=> trdy_b && devsel_b)
		else $error("select or ready held after last phase");
	AST_IDLE: assert property (!irdy_b && !trdy_b && frame_b |=> ##1
		(window_hit_o == '0 && local_transfer_strobe_low_o && !tgt_oe))
		else $error("idle clock not clean");
	cover property (!local_transfer_strobe_low_o);
	cover property (!irdy_b && !trdy_b && frame_b);
	cover property (!devsel_b && trdy_b && backend_ready_low_i);
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
`include "ptw_defs.svh"
module tb;
	logic clk_i = 1'b0, rst_b_i = 1'b0, start_i = 1'b0, ready_b = 1'b1, busy_o;
	logic [31:0] addr_i = 32'h0, wdata_i = 32'h0;
	logic [4:0] len_i = 5'h1;
	logic [3:0] be_b_i = 4'hf;
	logic ce = 1'b1, speed = `PTW_SPEED_SLOW;
	logic [1:0] window_hit_o;
	logic [31:0] local_target_address_out_o, local_data_out_o, bus_q[$];
	logic local_transfer_strobe_low_o;
	int num_errors = 0, cmp_count = 0, nstr = 0, cyc = 0;
	ptw_bus_if bif();
	ptw_master #(.MAX_BURST(16)) u_ptw_master (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
		.start_i(start_i), .addr_i(addr_i), .len_i(len_i), .wdata_i(wdata_i), .be_b_i(be_b_i),
		.wnext_o(), .busy_o(busy_o), .bus(bif.master));
	ptw_target #(.NUM_WIN(2), .BUS_WIDTH(64)) u_ptw_target (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.ce_i(ce), .select_response_speed_i(speed), .backend_ready_low_i(ready_b),
		.local_target_address_out_o(local_target_address_out_o), .window_hit_o(window_hit_o),
		.local_data_out_o(local_data_out_o),
		.local_transfer_strobe_low_o(local_transfer_strobe_low_o), .bus(bif.target));
	ptw_chk_sva #(.NUM_WIN(2)) u_ptw_chk_sva (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.frame_b(bif.frame_b), .irdy_b(bif.irdy_b), .trdy_b(bif.trdy_b),
		.devsel_b(bif.devsel_b), .tgt_oe(bif.tgt_oe), .ad(bif.ad), .cbe_b(bif.cbe_b),
		.select_response_speed_i(speed), .backend_ready_low_i(ready_b),
		.window_hit_o(window_hit_o),
		.local_target_address_out_o(local_target_address_out_o),
		.local_data_out_o(local_data_out_o),
		.local_transfer_strobe_low_o(local_transfer_strobe_low_o));
	initial forever #12.5 clk_i = ~clk_i;
	// ----
	// checking helpers
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		if (num_errors == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	function automatic logic [1:0] exp_hit(input logic [31:0] a);
		return {(a & `PTW_BAR1_MASK) == `PTW_BAR1_BASE, (a & `PTW_BAR0_MASK) == `PTW_BAR0_BASE};
	endfunction
	function automatic logic [31:0] pick_addr(input int k);
		logic [31:0] r;
		r = $urandom & 32'hfffc;
		case (k)
			0: return `PTW_BAR0_BASE | (r & 32'hffc);
			1: return `PTW_BAR1_BASE | r;
			default: return 32'h3000_0000 | r;
		endcase
	endfunction
	// words taken on the bus must reach the back-end in order
	always @(posedge clk_i) begin
		if (!bif.irdy_b && !bif.trdy_b) bus_q.push_back(bif.ad[31:0]);
		if (local_transfer_strobe_low_o === 1'b0) begin
			nstr++;
			chk(local_data_out_o, bus_q.size() ? bus_q.pop_front() : 32'hx);
		end
		if (++cyc == 8000) begin
			num_errors++;
			close_out();
		end
	end
	always @(negedge clk_i) begin
		wdata_i <= $urandom;
		be_b_i <= 4'($urandom);
	end
	// ----
	// one burst; stall keeps the back-end slow before data
	// ----
	task automatic burst(input logic [31:0] a, input logic [4:0] n, input int stall);
		int k;
		logic [1:0] eh;
		eh = exp_hit(a);
		@(negedge clk_i);
		nstr = 0;
		addr_i = a;
		len_i = n;
		start_i = 1'b1;
		ready_b = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		for (k = 0; k < 6 && window_hit_o === 2'h0; k++) @(negedge clk_i);
		chk({30'h0, window_hit_o}, {30'h0, eh});
		chk(local_target_address_out_o, a);
		repeat (stall) @(negedge clk_i);
		ready_b = 1'b0;
		for (k = 0; k < 100 && busy_o !== 1'b0; k++) @(negedge clk_i);
		repeat (4) @(negedge clk_i);
		chk(32'(nstr), (eh != 2'h0) ? 32'(n) : 32'h0);
		chk(32'(bus_q.size()), 32'h0);
	endtask
	initial begin
		void'($urandom(32'h4604));
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		rst_b_i = 1'b1;
		// clock enable low: a start pulse must leave the master idle
		ce = 1'b0;
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		repeat (2) @(negedge clk_i);
		ce = 1'b1;
		chk({31'h0, busy_o}, 32'h0);
		burst(`PTW_BAR0_BASE, 5'h1, 0);
		burst(`PTW_BAR1_BASE + 32'hfffc, 5'h10, 3);
		burst(`PTW_BAR0_BASE + 32'h1000, 5'h4, 0);
		for (int i = 0; i < 24; i++) burst(pick_addr($urandom % 3), 5'(1 + $urandom % 16), $urandom % 4);
		rst_b_i = 1'b0;
		@(negedge clk_i);
		rst_b_i = 1'b1;
		// fast select for the closing bursts
		speed = ~`PTW_SPEED_SLOW;
		burst(`PTW_BAR1_BASE, 5'h3, 1);
		burst(`PTW_BAR0_BASE + 32'h0ff0, 5'h2, 0);
		close_out();
	end
endmodule
